/* include/mii_port_pkg.sv */
// constants shared by the quad mii data port
package mii_port_pkg;
  localparam int NUM_PORTS = 4;
  localparam int NIBBLE_W = 4;
  // tx and rx clock rates, in kHz
  localparam int RATE_100_KHZ = 25000;
  localparam int RATE_10_KHZ = 2500;
  // link clock cycles per half period of the port clocks
  localparam logic [3:0] HALF_CNT_100 = 4'h1;
  localparam logic [3:0] HALF_CNT_10 = 4'(int'(HALF_CNT_100) * RATE_100_KHZ / RATE_10_KHZ);
  localparam logic [3:0] HALT_NIBBLE = 4'h0;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [3:0] FIBER_PORT_MASK = 4'ha;
endpackage

/* design/quad_phy_mii_data_port.sv */
// four independent mii data ports with their link-side clocking
// Notes on behaviour
// [RULE1] the mac presents each port's transmit data as a four-bit nrz nibble
// [RULE2] a port transmits only while its transmit enable is high
// [RULE3] each port drives its own transmit clock, 25 MHz or 2.5 MHz by speed
// [RULE4] the mac changes transmit inputs in step with that port's transmit clock
// [RULE5] transmit inputs are captured on the rising transmit clock by default
// [RULE6] with early sampling set, capture moves to the falling transmit clock
// [RULE7] transmit error high sends the halt code instead of data
// [RULE8] received data leaves as four-bit nibbles in step with the receive clock
// [RULE9] fiber operation exists on ports 1 and 3 only
// [RULE10] each port drives its own receive clock, 25 MHz or 2.5 MHz by speed
// [RULE11] receive valid is high while the received code maps to data
// [RULE12] receive error is high on an invalid code or an unlocked receive pll
// [RULE13] carrier covers tx and rx in half duplex, rx only in full duplex
// [RULE14] nibble bit 0 is least significant and first in time
// [RULE15] each port is its own instance with its own clocks and data path
`timescale 1ns/100ps
`default_nettype none

module mii_port
  import mii_port_pkg::*;
#(
  parameter bit FIBER_OK = 1'b0
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic linkClk,
  input wire logic speed100,
  input wire logic fullDuplex,
  input wire logic earlySample,
  input wire logic pllLocked,
  input wire logic rxCarrier,
  input wire logic signalDetectMediaSelect,
  output logic fiberActive,
  output logic [NIBBLE_W-1:0] txNibble,
  output logic txActive,
  output logic txHalt,
  output logic txStrobe,
  input wire logic [NIBBLE_W-1:0] rxNibbleIn,
  input wire logic rxValidIn,
  input wire logic rxCodeErrIn,
  input wire logic rxStrobeIn,
  output logic txClk,
  input wire logic [NIBBLE_W-1:0] txd,
  input wire logic txEn,
  input wire logic txEr,
  output logic rxClk,
  output logic [NIBBLE_W-1:0] rxd,
  output logic rxDv,
  output logic rxEr,
  output logic crs
);
  // ***************************************************************
  // link domain reset and configuration crossing
  // ***************************************************************
  logic lrstS1_ff, lrstS2_ff;
  logic [4:0] cfgS1_ff, cfgS2_ff;
  logic linkRstN, spdL, fullL, earlyL, pllL, carrL;

  always_ff @(posedge linkClk or negedge nrst)
  begin
    if (!nrst)
    begin
      lrstS1_ff <= 1'b0;
      lrstS2_ff <= 1'b0;
    end
    else
    begin
      lrstS1_ff <= 1'b1;
      lrstS2_ff <= lrstS1_ff;
    end
  end
  assign linkRstN = lrstS2_ff;

  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      cfgS1_ff <= 5'h00;
      cfgS2_ff <= 5'h00;
    end
    else
    begin
      cfgS1_ff <= {speed100, fullDuplex, earlySample, pllLocked, rxCarrier};
      cfgS2_ff <= cfgS1_ff;
    end
  end
  assign {spdL, fullL, earlyL, pllL, carrL} = cfgS2_ff;

  // ***************************************************************
  // port clock dividers
  // ***************************************************************
  logic [3:0] halfCnt, txCnt_ff, rxCnt_ff;
  logic txClk_ff, rxClk_ff, txTick, rxTick;

  assign halfCnt = spdL ? HALF_CNT_100 : HALF_CNT_10;
  // >= so a speed change never strands the counter above the limit
  assign txTick = (txCnt_ff >= halfCnt - 4'h1);
  assign rxTick = (rxCnt_ff >= halfCnt - 4'h1);

  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      txCnt_ff <= 4'h0;
      txClk_ff <= 1'b0;
    end
    else
    begin
      txCnt_ff <= txTick ? 4'h0 : txCnt_ff + 4'h1;
      txClk_ff <= txTick ? ~txClk_ff : txClk_ff; // RULE3
    end
  end

  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      rxCnt_ff <= 4'h0;
      rxClk_ff <= 1'b0;
    end
    else
    begin
      rxCnt_ff <= rxTick ? 4'h0 : rxCnt_ff + 4'h1;
      rxClk_ff <= rxTick ? ~rxClk_ff : rxClk_ff; // RULE10
    end
  end
  assign txClk = txClk_ff;
  assign rxClk = rxClk_ff;

  // ***************************************************************
  // transmit capture on the link side
  // ***************************************************************
  logic [5:0] txPinS1_ff, txPinS2_ff, txHold_ff;
  logic capPre_ff, capMark_ff, txTgl_ff, crs_ff;

  // mark trails the edge by two cycles, the synchroniser depth, so hold gets pins at the edge
  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      txPinS1_ff <= 6'h00;
      txPinS2_ff <= 6'h00;
      capPre_ff <= 1'b0;
      capMark_ff <= 1'b0;
      txHold_ff <= 6'h00;
      txTgl_ff <= 1'b0;
    end
    else
    begin
      txPinS1_ff <= {txEr, txEn, txd}; // RULE1 RULE4
      txPinS2_ff <= txPinS1_ff;
      capPre_ff <= txTick & (earlyL ? txClk_ff : ~txClk_ff); // RULE5 RULE6
      capMark_ff <= capPre_ff;
      if (capMark_ff)
      begin
        txHold_ff <= txPinS2_ff;
        txTgl_ff <= ~txTgl_ff;
      end
    end
  end

  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
      crs_ff <= 1'b0;
    else
      crs_ff <= carrL | (~fullL & txHold_ff[4]); // RULE13
  end
  assign crs = crs_ff;

  // ***************************************************************
  // transmit hand-over to the core clock
  // ***************************************************************
  logic txTglS1_ff, txTglS2_ff, txTglS3_ff, txNew;
  logic [NIBBLE_W-1:0] txNibble_ff;
  logic txActive_ff, txHalt_ff, txStrobe_ff;

  assign txNew = txTglS2_ff ^ txTglS3_ff;
  // hold is stable two link cycles, longer than the toggle takes to cross
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txTglS1_ff <= 1'b0;
      txTglS2_ff <= 1'b0;
      txTglS3_ff <= 1'b0;
      txNibble_ff <= RST_NIBBLE;
      txActive_ff <= 1'b0;
      txHalt_ff <= 1'b0;
      txStrobe_ff <= 1'b0;
    end
    else
    begin
      txTglS1_ff <= txTgl_ff;
      txTglS2_ff <= txTglS1_ff;
      txTglS3_ff <= txTglS2_ff;
      txStrobe_ff <= txNew & txHold_ff[4]; // RULE2
      if (txNew)
      begin
        txActive_ff <= txHold_ff[4]; // RULE2
        txHalt_ff <= txHold_ff[5]; // RULE7
        txNibble_ff <= txHold_ff[5] ? HALT_NIBBLE : txHold_ff[3:0]; // RULE7 RULE14
      end
    end
  end
  assign txNibble = txNibble_ff;
  assign txActive = txActive_ff;
  assign txHalt = txHalt_ff;
  assign txStrobe = txStrobe_ff;

  // ***************************************************************
  // receive path and media select
  // ***************************************************************
  logic [5:0] rxHold_ff, rxPend_ff;
  logic rxTgl_ff, sdS1_ff, sdS2_ff, fiber_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rxHold_ff <= 6'h00;
      rxTgl_ff <= 1'b0;
      sdS1_ff <= 1'b0;
      sdS2_ff <= 1'b0;
      fiber_ff <= 1'b0;
    end
    else
    begin
      if (rxStrobeIn)
      begin
        rxHold_ff <= {rxCodeErrIn, rxValidIn, rxNibbleIn};
        rxTgl_ff <= ~rxTgl_ff;
      end
      sdS1_ff <= signalDetectMediaSelect;
      sdS2_ff <= sdS1_ff;
      fiber_ff <= FIBER_OK & sdS2_ff; // RULE9
    end
  end
  assign fiberActive = fiber_ff;

  logic rxTglS1_ff, rxTglS2_ff, rxTglS3_ff, rxUpd;
  logic [NIBBLE_W-1:0] rxd_ff;
  logic rxDv_ff, rxEr_ff;

  // outputs move on the falling receive clock, stable at the rising one
  assign rxUpd = rxTick & rxClk_ff;
  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      rxTglS1_ff <= 1'b0;
      rxTglS2_ff <= 1'b0;
      rxTglS3_ff <= 1'b0;
      rxPend_ff <= 6'h00;
      rxd_ff <= RST_NIBBLE;
      rxDv_ff <= 1'b0;
      rxEr_ff <= 1'b0;
    end
    else
    begin
      rxTglS1_ff <= rxTgl_ff;
      rxTglS2_ff <= rxTglS1_ff;
      rxTglS3_ff <= rxTglS2_ff;
      if (rxTglS2_ff ^ rxTglS3_ff)
        rxPend_ff <= rxHold_ff;
      if (rxUpd)
      begin
        rxd_ff <= rxPend_ff[3:0]; // RULE8 RULE14
        rxDv_ff <= rxPend_ff[4]; // RULE11
        rxEr_ff <= rxPend_ff[5] | ~pllL; // RULE12
      end
    end
  end
  assign rxd = rxd_ff;
  assign rxDv = rxDv_ff;
  assign rxEr = rxEr_ff;

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence txEdgeSeen;
    txTick ##1 capPre_ff ##1 capMark_ff;
  endsequence

  chk_tx_halt_data: assert property (@(posedge clk) disable iff (!nrst) // RULE7
    txHalt_ff |-> txNibble_ff == HALT_NIBBLE) else $error("halt nibble not sent");
  chk_tx_strobe_enable: assert property (@(posedge clk) disable iff (!nrst) // RULE2
    txStrobe_ff |-> txActive_ff && !$past(txStrobe_ff)) else $error("strobe while idle");
  chk_txclk_fast_rate: assert property (@(posedge linkClk) disable iff (!linkRstN) // RULE3
    spdL [*2] |-> txClk_ff != $past(txClk_ff)) else $error("fast tx clock not toggling");
  chk_txclk_slow_rate: assert property (@(posedge linkClk) disable iff (!linkRstN) // RULE3
    $rose(txClk_ff) && !spdL |=> txClk_ff [*8]) else $error("slow tx clock half too short");
  chk_rxclk_track: assert property (@(posedge linkClk) disable iff (!linkRstN) // RULE10
    rxClk_ff == txClk_ff && rxCnt_ff == txCnt_ff) else $error("rx clock off rate");
  chk_tx_sample_edge: assert property (@(posedge linkClk) disable iff (!linkRstN) // RULE5 RULE6
    txEdgeSeen |-> $past(earlyL, 2) ? !$past(txClk_ff) : $past(txClk_ff))
    else $error("wrong capture edge");
  chk_tx_capture_value: assert property (@(posedge linkClk) disable iff (!linkRstN) // RULE1
    capMark_ff |=> txHold_ff == $past(txPinS2_ff) && txTgl_ff != $past(txTgl_ff))
    else $error("tx nibble not captured");
  chk_rx_nibble_out: assert property (@(posedge linkClk) disable iff (!linkRstN) // RULE8
    rxUpd |=> rxd_ff == $past(rxPend_ff[3:0]) && rxDv_ff == $past(rxPend_ff[4]))
    else $error("rx nibble not driven");
  chk_rx_err_pll: assert property (@(posedge linkClk) disable iff (!linkRstN) // RULE12
    rxUpd && !pllL |=> rxEr_ff) else $error("rx error missing on unlocked pll");
  chk_crs_duplex: assert property (@(posedge linkClk) disable iff (!linkRstN) // RULE13
    !carrL && (fullL || !txHold_ff[4]) |=> !crs_ff) else $error("carrier without activity");
  chk_crs_half_tx: assert property (@(posedge linkClk) disable iff (!linkRstN) // RULE13
    !fullL && txHold_ff[4] |=> crs_ff) else $error("carrier missing on transmit");
  chk_fiber_ports: assert property (@(posedge clk) disable iff (!nrst) // RULE9
    !FIBER_OK |-> !fiber_ff) else $error("fiber on a copper-only port");
endmodule

module quad_phy_mii_data_port
  import mii_port_pkg::*;
#(
  parameter logic [NUM_PORTS-1:0] FIBER_MASK = FIBER_PORT_MASK
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic linkClk,
  input wire logic [NUM_PORTS-1:0] speed100,
  input wire logic [NUM_PORTS-1:0] fullDuplex,
  input wire logic [NUM_PORTS-1:0] earlySample,
  input wire logic [NUM_PORTS-1:0] pllLocked,
  input wire logic [NUM_PORTS-1:0] rxCarrier,
  input wire logic [NUM_PORTS-1:0] signalDetectMediaSelect,
  output logic [NUM_PORTS-1:0] fiberActive,
  output logic [NUM_PORTS*NIBBLE_W-1:0] txNibble,
  output logic [NUM_PORTS-1:0] txActive,
  output logic [NUM_PORTS-1:0] txHalt,
  output logic [NUM_PORTS-1:0] txStrobe,
  input wire logic [NUM_PORTS*NIBBLE_W-1:0] rxNibbleIn,
  input wire logic [NUM_PORTS-1:0] rxValidIn,
  input wire logic [NUM_PORTS-1:0] rxCodeErrIn,
  input wire logic [NUM_PORTS-1:0] rxStrobeIn,
  output logic [NUM_PORTS-1:0] txClk,
  input wire logic [NUM_PORTS*NIBBLE_W-1:0] txd,
  input wire logic [NUM_PORTS-1:0] txEn,
  input wire logic [NUM_PORTS-1:0] txEr,
  output logic [NUM_PORTS-1:0] rxClk,
  output logic [NUM_PORTS*NIBBLE_W-1:0] rxd,
  output logic [NUM_PORTS-1:0] rxDv,
  output logic [NUM_PORTS-1:0] rxEr,
  output logic [NUM_PORTS-1:0] crs
);
  // one self-contained instance per port, nothing shared but clocks and reset
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    mii_port #(.FIBER_OK(FIBER_MASK[p])) u_port ( // RULE15 RULE9
      .clk(clk),
      .nrst(nrst),
      .linkClk(linkClk),
      .speed100(speed100[p]),
      .fullDuplex(fullDuplex[p]),
      .earlySample(earlySample[p]),
      .pllLocked(pllLocked[p]),
      .rxCarrier(rxCarrier[p]),
      .signalDetectMediaSelect(signalDetectMediaSelect[p]),
      .fiberActive(fiberActive[p]),
      .txNibble(txNibble[p*NIBBLE_W +: NIBBLE_W]),
      .txActive(txActive[p]),
      .txHalt(txHalt[p]),
      .txStrobe(txStrobe[p]),
      .rxNibbleIn(rxNibbleIn[p*NIBBLE_W +: NIBBLE_W]),
      .rxValidIn(rxValidIn[p]),
      .rxCodeErrIn(rxCodeErrIn[p]),
      .rxStrobeIn(rxStrobeIn[p]),
      .txClk(txClk[p]),
      .txd(txd[p*NIBBLE_W +: NIBBLE_W]),
      .txEn(txEn[p]),
      .txEr(txEr[p]),
      .rxClk(rxClk[p]),
      .rxd(rxd[p*NIBBLE_W +: NIBBLE_W]),
      .rxDv(rxDv[p]),
      .rxEr(rxEr[p]),
      .crs(crs[p])
    );
  end
endmodule

`default_nettype wire

/* test/mac_model.sv */
// mac side model driving the transmit pins of the four ports
`timescale 1ns/100ps
`default_nettype none

module mac_model
  import mii_port_pkg::*;
(
  input wire logic [NUM_PORTS-1:0] txClk,
  input wire logic [NUM_PORTS*NIBBLE_W-1:0] nibbleReq,
  input wire logic [NUM_PORTS-1:0] enReq,
  input wire logic [NUM_PORTS-1:0] erReq,
  output logic [NUM_PORTS*NIBBLE_W-1:0] txd,
  output logic [NUM_PORTS-1:0] txEn,
  output logic [NUM_PORTS-1:0] txEr
);
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_port
    initial
    begin
      txd[4*p+:4] = 4'h0;
      txEn[p] = 1'h0;
      txEr[p] = 1'h0;
    end
    // pins move only on the port's own clock rise, so both capture edges see stable data
    always @(posedge txClk[p])
    begin
      txd[4*p+:4] <= nibbleReq[4*p+:4];
      txEn[p] <= enReq[p];
      txEr[p] <= erReq[p];
    end
  end
endmodule
`default_nettype wire

/* test/quad_phy_mii_data_port_tb.sv */
// self-checking bench for the quad mii data port
`timescale 1ns/100ps
`default_nettype none

module quad_phy_mii_data_port_tb
  import mii_port_pkg::*;
;
  typedef struct packed {
    logic [3:0] nib;
    logic en, er, early, fdx, car, pll;
    logic [3:0] rxn;
    logic rxv, rxe;
    logic [3:0] eNib;
    logic eAct, eHalt, eCrs, eRxEr;
  } row_s;
  // ****************
  // stimulus rows
  // ****************
  row_s rows[6] = '{
    '{4'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 4'h8, 1'h1, 1'h0, 4'h1, 1'h1, 1'h0, 1'h1, 1'h0},
    '{4'h8, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 4'h1, 1'h1, 1'h1, 4'h8, 1'h1, 1'h0, 1'h0, 1'h1},
    '{4'h5, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 4'ha, 1'h0, 1'h0, 4'h0, 1'h1, 1'h1, 1'h1, 1'h0},
    '{4'ha, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 4'h5, 1'h1, 1'h0, 4'ha, 1'h0, 1'h0, 1'h1, 1'h1},
    '{4'h3, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 4'h0, 1'h0, 1'h0, 4'h3, 1'h0, 1'h0, 1'h0, 1'h0},
    '{4'hc, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 4'hf, 1'h1, 1'h0, 4'hc, 1'h1, 1'h0, 1'h1, 1'h0}};
  logic clk = 1'h0;
  logic linkClk = 1'h0;
  logic nrst = 1'h0;
  logic [3:0] speed100, fullDuplex, earlySample, pllLocked, rxCarrier;
  logic [3:0] signalDetectMediaSelect, fiberActive, txActive, txHalt, txStrobe, txClk;
  logic [3:0] rxValidIn, rxCodeErrIn, rxStrobeIn, txEn, txEr, rxClk, rxDv, rxEr, crs;
  logic [3:0] enReq, erReq;
  logic [15:0] txNibble, rxNibbleIn, txd, rxd, nibbleReq;
  int error_cnt = 0;
  int n_compared = 0;
  int nStrobe = 0;
  always #4 clk = ~clk;
  always #15 linkClk = ~linkClk;
  always @(posedge clk)
    if (txStrobe[0] === 1'h1)
      nStrobe <= nStrobe + 1;
  quad_phy_mii_data_port dut_u (.clk, .nrst, .linkClk, .speed100, .fullDuplex, .earlySample,
    .pllLocked, .rxCarrier, .signalDetectMediaSelect, .fiberActive, .txNibble, .txActive,
    .txHalt, .txStrobe, .rxNibbleIn, .rxValidIn, .rxCodeErrIn, .rxStrobeIn, .txClk, .txd, .txEn,
    .txEr, .rxClk, .rxd, .rxDv, .rxEr, .crs);
  mac_model mac_u (.txClk, .nibbleReq, .enReq, .erReq, .txd, .txEn, .txEr);
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // link side resets asynchronously, so three core cycles are enough
  task automatic do_reset();
    nrst = 1'h0;
    repeat (3) @(negedge clk);
    chk({txClk, rxClk, crs, txStrobe}, 16'h0, "reset outputs");
    chk(rxd | txNibble, 16'h0, "reset nibbles");
    nrst = 1'h1;
  endtask
  task automatic period(input int p, input logic [15:0] exp);
    realtime t0;
    @(posedge txClk[p]);
    t0 = $realtime;
    @(posedge txClk[p]);
    chk(16'($rtoi($realtime - t0)), exp, "clock period");
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    row_s r;
    int n0;
    speed100 = 4'hf;
    {fullDuplex, earlySample, rxCarrier, signalDetectMediaSelect} = 16'h0;
    pllLocked = 4'hf;
    {rxNibbleIn, rxValidIn, rxCodeErrIn, rxStrobeIn} = 28'h0;
    {nibbleReq, enReq, erReq} = 24'h0;
    do_reset();
    foreach (rows[i])
    begin
      r = rows[i];
      @(negedge clk);
      earlySample = {4{r.early}};
      fullDuplex = {4{r.fdx}};
      rxCarrier = {4{r.car}};
      pllLocked = {4{r.pll}};
      for (int p = 0; p < 4; p++)
      begin
        nibbleReq[4*p+:4] = r.nib ^ 4'(p);
        rxNibbleIn[4*p+:4] = r.rxn ^ 4'(p);
      end
      {enReq, erReq} = {{4{r.en}}, {4{r.er}}};
      {rxValidIn, rxCodeErrIn, rxStrobeIn} = {{4{r.rxv}}, {4{r.rxe}}, 4'hf};
      @(negedge clk);
      rxStrobeIn = 4'h0;
      repeat (50) @(negedge clk);
      @(posedge txClk[0]);
      n0 = nStrobe;
      repeat (10) @(posedge txClk[0]);
      chk(16'(nStrobe - n0 inside {[9:11]}), 16'(r.eAct), "strobes");
      chk(16'(nStrobe - n0), 16'(nStrobe - n0) & {16{r.eAct}}, "idle strobes");
      @(negedge clk);
      for (int p = 0; p < 4; p++)
      begin
        chk(16'(txNibble[4*p+:4]), 16'(r.eHalt ? r.eNib : r.eNib ^ 4'(p)), "tx nib");
        chk(16'(rxd[4*p+:4]), 16'(r.rxn ^ 4'(p)), "rx nib");
      end
      chk({4'h0, txActive, txHalt, crs}, {4'h0, {4{r.eAct}}, {4{r.eHalt}}, {4{r.eCrs}}}, "tx");
      chk(16'({rxDv, rxEr}), 16'({{4{r.rxv}}, {4{r.eRxEr}}}), "rx flags");
      chk(16'(rxClk), 16'(txClk), "clock phase");
    end
    // ports at different speeds at once
    speed100 = 4'h5;
    repeat (200) @(negedge clk);
    period(0, 16'h3c);
    period(1, 16'h258);
    @(negedge clk);
    chk(16'(rxClk), 16'(txClk), "slow clock phase");
    signalDetectMediaSelect = 4'hf;
    repeat (6) @(negedge clk);
    chk(16'(fiberActive), 16'(FIBER_PORT_MASK), "fiber ports");
    speed100 = 4'hf;
    do_reset();
    repeat (100) @(negedge clk);
    chk(16'(txActive), 16'hf, "after reset");
    close_out();
  end
  initial
  begin
    #200000;
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
`default_nettype wire
